/* File: sqwrc_pkg.sv */
// Purpose: Shared constants and types for the square-wave and user RAM clear block
// Assumes: APB register bus with 32-bit data, 12-bit byte address
// Notes: Offsets are byte addresses; user RAM bytes occupy one word each
package sqwrc_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int RAM_BYTES = 114;
	localparam int RAM_AW = 7;
	localparam int DIV_STAGES = 15;
	localparam int CLR_W = 3;

	localparam logic [11:0] OFF_CTRL_A = 12'h000;
	localparam logic [11:0] OFF_CTRL_B = 12'h004;
	localparam logic [11:0] OFF_EXT_CTRL = 12'h008;
	localparam logic [11:0] OFF_STATUS = 12'h00C;
	localparam logic [11:0] OFF_RAM_BASE = 12'h200;
	localparam logic [6:0] RAM_LAST = 7'h71;

	// Control A: rate select [3:0], divider control [6:4]
	localparam int RS_LSB = 0;
	localparam int DV_LSB = 4;
	// Control B: square wave enable
	localparam int SQ_ENABLE_BIT = 3;
	// Extended control: forced 32 kHz [0], aux battery enable [1]
	localparam int FORCE_32K_BIT = 0;
	localparam int AUX_ENABLE_BIT = 1;
	// Status: power good [0], aux present [1], clear active [2], output driven [3]
	localparam int ST_PWR_BIT = 0;
	localparam int ST_AUX_BIT = 1;
	localparam int ST_CLR_BIT = 2;
	localparam int ST_DRV_BIT = 3;

	localparam logic [3:0] RS_RST = 4'h0;
	localparam logic [2:0] DV_RST = 3'h0;
	localparam logic [2:0] DV_CHAIN_RESET = 3'h6;
	localparam int DIV_CTRL_BIT1 = 1;
	localparam logic [7:0] RAM_CLEAR_VAL = 8'hFF;
	// Sync order {osc, vcc_ok, aux, clear_n}; clear_n rests high
	localparam logic [3:0] SYNC_RST = 4'h1;

	// Rate codes with fixed taps; codes 3..15 map to stage code-2
	localparam logic [3:0] RS_256HZ = 4'h1;
	localparam logic [3:0] RS_128HZ = 4'h2;
	localparam int TAP_256HZ = 6;
	localparam int TAP_128HZ = 7;
	localparam int TAP_OFFSET = 2;

	typedef struct packed {
		logic [2:0] divider_ctrl;
		logic [3:0] rate_sel;
	} sqwrc_ctrl_a_s;

	typedef struct packed {
		logic aux_battery_enable;
		logic force_32k_enable;
	} sqwrc_ext_s;

	typedef enum logic [1:0] {
		CLR_IDLE = 2'b00,
		CLR_SWEEP = 2'b01,
		CLR_HOLD = 2'b11
	} sqwrc_clr_e;
endpackage

/* File: sqwrc_ram.sv */
// Purpose: User RAM array, one write port and one registered read port
// Assumes: Single clock, write and read may occur in the same cycle
// Notes: Read data reflect contents before a same-cycle write
`timescale 1ns/1ps
module sqwrc_ram (
	input wire logic clk,
	input wire logic we,
	input wire logic [sqwrc_pkg::RAM_AW-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic re,
	input wire logic [sqwrc_pkg::RAM_AW-1:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:sqwrc_pkg::RAM_BYTES-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (re) begin
			rdata <= mem[raddr];
		end
	end
endmodule // sqwrc_ram

/* File: sqwrc_top.sv */
// Purpose: Square-wave output selection and gating, user RAM clear, power-fail access lock
// Assumes: pclk 25 MHz; oscillator, supply and clear inputs are asynchronous pins
// Notes: Every APB access takes one wait state; square_wave_oe_n is low while driving
`timescale 1ns/1ps
module sqwrc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sqwrc_pkg::ADDR_W-1:0] paddr,
	input wire logic [sqwrc_pkg::DATA_W-1:0] pwdata,
	output logic [sqwrc_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic osc_32k_in,
	input wire logic vcc_above_trip,
	input wire logic aux_battery_in,
	input wire logic user_ram_clear_n,
	output logic square_wave_out,
	output logic square_wave_oe_n
);
	// Input synchronisers
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic osc_s;
	logic pwr_ok;
	logic aux_present;
	logic clear_n_s;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= sqwrc_pkg::SYNC_RST;
			sync2_q <= sqwrc_pkg::SYNC_RST;
		end else begin
			sync1_q <= {osc_32k_in, vcc_above_trip, aux_battery_in, user_ram_clear_n};
			sync2_q <= sync1_q;
		end
	end

	assign osc_s = sync2_q[3];
	assign pwr_ok = sync2_q[2];
	assign aux_present = sync2_q[1];
	assign clear_n_s = sync2_q[0];

	// Edge detectors on synchronised levels
	logic osc_prev_q;
	logic pwr_prev_q;
	logic osc_tick;
	logic pwr_rise;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_prev_q <= 1'b0;
			pwr_prev_q <= 1'b0;
		end else begin
			osc_prev_q <= osc_s;
			pwr_prev_q <= pwr_ok;
		end
	end

	assign osc_tick = osc_s & ~osc_prev_q;
	assign pwr_rise = pwr_ok & ~pwr_prev_q;

	// APB decode
	logic setup_ph;
	logic access_ph;
	logic wait_q;
	logic wr_commit;
	logic rd_capture;
	logic is_ram;
	logic [sqwrc_pkg::ADDR_W-1:0] ram_off;
	logic [sqwrc_pkg::RAM_AW-1:0] ram_idx;
	logic addr_hit;
	logic access_err;

	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable;
	assign ram_off = paddr - sqwrc_pkg::OFF_RAM_BASE;
	assign ram_idx = ram_off[sqwrc_pkg::RAM_AW+1:2];
	assign is_ram = (paddr >= sqwrc_pkg::OFF_RAM_BASE) && (paddr[1:0] == 2'b00)
		&& (ram_idx <= sqwrc_pkg::RAM_LAST)
		&& (ram_off[sqwrc_pkg::ADDR_W-1:sqwrc_pkg::RAM_AW+2] == '0);

	always_comb begin
		unique case (paddr)
			sqwrc_pkg::OFF_CTRL_A,
			sqwrc_pkg::OFF_CTRL_B,
			sqwrc_pkg::OFF_EXT_CTRL,
			sqwrc_pkg::OFF_STATUS: addr_hit = 1'b1;
			default: addr_hit = is_ram;
		endcase
	end

	// Locked out accesses still complete, so a host never hangs on a dead part
	assign access_err = ~addr_hit | ~pwr_ok;
	assign pready = access_ph & wait_q;
	assign wr_commit = pready & pwrite & ~access_err;
	assign rd_capture = access_ph & ~wait_q & ~pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q <= 1'b0;
		end else if (access_ph && !wait_q) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else if (access_ph && !wait_q) begin
			pslverr <= access_err;
		end else begin
			pslverr <= 1'b0;
		end
	end

	// Control registers
	sqwrc_pkg::sqwrc_ctrl_a_s ctrl_a_q;
	logic sq_enable_q;
	sqwrc_pkg::sqwrc_ext_s ext_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_a_q.rate_sel <= sqwrc_pkg::RS_RST;
		end else if (wr_commit && paddr == sqwrc_pkg::OFF_CTRL_A) begin
			ctrl_a_q.rate_sel <= pwdata[sqwrc_pkg::RS_LSB +: 4];
		end
	end

	// Power-up set wins over a same-cycle software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_a_q.divider_ctrl <= sqwrc_pkg::DV_RST;
		end else begin
			if (wr_commit && paddr == sqwrc_pkg::OFF_CTRL_A) begin
				ctrl_a_q.divider_ctrl <= pwdata[sqwrc_pkg::DV_LSB +: 3];
			end
			if (pwr_rise) begin
				ctrl_a_q.divider_ctrl[sqwrc_pkg::DIV_CTRL_BIT1] <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sq_enable_q <= 1'b0;
		end else if (wr_commit && paddr == sqwrc_pkg::OFF_CTRL_B) begin
			sq_enable_q <= pwdata[sqwrc_pkg::SQ_ENABLE_BIT];
		end
	end

	// Aux enable is purely software owned; the host keeps it zero without an aux cell
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_q.aux_battery_enable <= 1'b0;
		end else if (wr_commit && paddr == sqwrc_pkg::OFF_EXT_CTRL) begin
			ext_q.aux_battery_enable <= pwdata[sqwrc_pkg::AUX_ENABLE_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_q.force_32k_enable <= 1'b0;
		end else if (pwr_rise) begin
			ext_q.force_32k_enable <= 1'b1;
		end else if (wr_commit && paddr == sqwrc_pkg::OFF_EXT_CTRL) begin
			ext_q.force_32k_enable <= pwdata[sqwrc_pkg::FORCE_32K_BIT];
		end
	end

	// Divider chain, advanced once per oscillator rising edge
	logic [sqwrc_pkg::DIV_STAGES-1:0] div_q;
	logic chain_reset;

	assign chain_reset = (ctrl_a_q.divider_ctrl[2:1] == sqwrc_pkg::DV_CHAIN_RESET[2:1]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= '0;
		end else if (chain_reset) begin
			div_q <= '0;
		end else if (osc_tick) begin
			div_q <= div_q + 15'h0001;
		end
	end

	// Tap select: rate 0 gives no tap, 1 and 2 the slow prescaler taps, 3..15 stage rate-2
	logic tap_wave;
	logic tap_valid;

	always_comb begin
		tap_wave = 1'b0;
		tap_valid = 1'b1;
		unique case (ctrl_a_q.rate_sel)
			4'h0: tap_valid = 1'b0;
			sqwrc_pkg::RS_256HZ: tap_wave = div_q[sqwrc_pkg::TAP_256HZ];
			sqwrc_pkg::RS_128HZ: tap_wave = div_q[sqwrc_pkg::TAP_128HZ];
			default: tap_wave = div_q[4'(ctrl_a_q.rate_sel - sqwrc_pkg::TAP_OFFSET)];
		endcase
	end

	// Output selection and drive
	logic out_enabled;
	logic aux_keepalive;
	logic wave_d;
	logic oe_n_d;

	assign out_enabled = sq_enable_q | ext_q.force_32k_enable;
	assign aux_keepalive = ext_q.force_32k_enable & ext_q.aux_battery_enable
		& aux_present;

	always_comb begin
		wave_d = 1'b0;
		oe_n_d = 1'b1;
		if (pwr_ok) begin
			oe_n_d = 1'b0;
			if (ext_q.force_32k_enable) begin
				wave_d = osc_s;
			end else if (out_enabled) begin
				wave_d = tap_wave & tap_valid;
			end else begin
				wave_d = 1'b0;
			end
		end else if (aux_keepalive) begin
			oe_n_d = 1'b0;
			wave_d = osc_s;
		end else begin
			oe_n_d = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			square_wave_out <= 1'b0;
			square_wave_oe_n <= 1'b1;
		end else begin
			square_wave_out <= wave_d;
			square_wave_oe_n <= oe_n_d;
		end
	end

	// RAM clear sequencer; deliberately not gated by supply state
	sqwrc_pkg::sqwrc_clr_e clr_state_q;
	logic [sqwrc_pkg::RAM_AW-1:0] clr_addr_q;
	logic clr_busy;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clr_state_q <= sqwrc_pkg::CLR_IDLE;
		end else begin
			unique case (clr_state_q)
				sqwrc_pkg::CLR_IDLE: begin
					if (!clear_n_s) begin
						clr_state_q <= sqwrc_pkg::CLR_SWEEP;
					end
				end
				sqwrc_pkg::CLR_SWEEP: begin
					if (clr_addr_q == sqwrc_pkg::RAM_LAST) begin
						clr_state_q <= sqwrc_pkg::CLR_HOLD;
					end
				end
				sqwrc_pkg::CLR_HOLD: begin
					if (clear_n_s) begin
						clr_state_q <= sqwrc_pkg::CLR_IDLE;
					end
				end
				default: clr_state_q <= sqwrc_pkg::CLR_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clr_addr_q <= '0;
		end else if (clr_state_q == sqwrc_pkg::CLR_SWEEP) begin
			clr_addr_q <= clr_addr_q + 7'h01;
		end else begin
			clr_addr_q <= '0;
		end
	end

	// Host writes are blocked while the switch is held so the bytes stay cleared
	assign clr_busy = (clr_state_q != sqwrc_pkg::CLR_IDLE) | ~clear_n_s;

	logic ram_we;
	logic [sqwrc_pkg::RAM_AW-1:0] ram_waddr;
	logic [7:0] ram_wdata;
	logic [7:0] ram_rdata;

	always_comb begin
		ram_we = 1'b0;
		ram_waddr = ram_idx;
		ram_wdata = pwdata[7:0];
		if (clr_state_q == sqwrc_pkg::CLR_SWEEP) begin
			ram_we = 1'b1;
			ram_waddr = clr_addr_q;
			ram_wdata = sqwrc_pkg::RAM_CLEAR_VAL;
		end else if (wr_commit && is_ram && !clr_busy) begin
			ram_we = 1'b1;
		end
	end

	sqwrc_ram u_ram (
		.clk(pclk),
		.we(ram_we),
		.waddr(ram_waddr),
		.wdata(ram_wdata),
		.re(setup_ph & is_ram),
		.raddr(ram_idx),
		.rdata(ram_rdata)
	);

	// Read data, captured in the first access cycle
	logic [sqwrc_pkg::DATA_W-1:0] rd_mux;

	always_comb begin
		rd_mux = '0;
		if (!access_err) begin
			if (is_ram) begin
				rd_mux[7:0] = ram_rdata;
			end else begin
				unique case (paddr)
					sqwrc_pkg::OFF_CTRL_A: begin
						rd_mux[sqwrc_pkg::RS_LSB +: 4] = ctrl_a_q.rate_sel;
						rd_mux[sqwrc_pkg::DV_LSB +: 3] = ctrl_a_q.divider_ctrl;
					end
					sqwrc_pkg::OFF_CTRL_B: rd_mux[sqwrc_pkg::SQ_ENABLE_BIT] = sq_enable_q;
					sqwrc_pkg::OFF_EXT_CTRL: begin
						rd_mux[sqwrc_pkg::FORCE_32K_BIT] = ext_q.force_32k_enable;
						rd_mux[sqwrc_pkg::AUX_ENABLE_BIT] = ext_q.aux_battery_enable;
					end
					sqwrc_pkg::OFF_STATUS: begin
						rd_mux[sqwrc_pkg::ST_PWR_BIT] = pwr_ok;
						rd_mux[sqwrc_pkg::ST_AUX_BIT] = aux_present;
						rd_mux[sqwrc_pkg::ST_CLR_BIT] = clr_busy;
						rd_mux[sqwrc_pkg::ST_DRV_BIT] = ~square_wave_oe_n;
					end
					default: rd_mux = '0;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (rd_capture) begin
			prdata <= rd_mux;
		end
	end
endmodule // sqwrc_top

/* File: sqwrc_assertions.sv */
// Purpose: Port checks for sqwrc_top
// Assumes: Supply pins held for several pclk cycles
// Notes: Counters give the pin synchronisers time to settle
`timescale 1ns/1ps
module sqwrc_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sqwrc_pkg::ADDR_W-1:0] paddr,
	input wire logic [sqwrc_pkg::DATA_W-1:0] pwdata,
	input wire logic [sqwrc_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic osc_32k_in,
	input wire logic vcc_above_trip,
	input wire logic aux_battery_in,
	input wire logic user_ram_clear_n,
	input wire logic square_wave_out,
	input wire logic square_wave_oe_n
);
	logic [2:0] pf_q;
	logic [2:0] pa_q;
	logic [2:0] pg_q;
	// Saturating run lengths of each supply state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pf_q <= 3'h0;
			pa_q <= 3'h0;
			pg_q <= 3'h0;
		end else begin
			pf_q <= vcc_above_trip ? 3'h0 : pf_q + {2'h0, pf_q != 3'h7};
			pa_q <= (vcc_above_trip | aux_battery_in) ? 3'h0 : pa_q + {2'h0, pa_q != 3'h7};
			pg_q <= !vcc_above_trip ? 3'h0 : pg_q + {2'h0, pg_q != 3'h7};
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("wait state count wrong");
	a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read data not zero");
	a_pf_refuse: assert property (pready && pf_q >= 3'h6 |-> pslverr)
		else $error("access taken in power fail");
	a_pg_accept: assert property (pready && pg_q >= 3'h6 && paddr < 12'h010 |-> !pslverr)
		else $error("access refused with power good");
	a_pf_float: assert property (pa_q >= 3'h6 |-> square_wave_oe_n)
		else $error("pin driven in power fail");
	a_pg_drive: assert property (pg_q >= 3'h6 |-> !square_wave_oe_n)
		else $error("pin floats with power good");
endmodule // sqwrc_assertions
bind sqwrc_top sqwrc_assertions sqwrc_assertions_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_32k_in(osc_32k_in),
	.vcc_above_trip(vcc_above_trip), .aux_battery_in(aux_battery_in),
	.user_ram_clear_n(user_ram_clear_n), .square_wave_out(square_wave_out),
	.square_wave_oe_n(square_wave_oe_n));

/* File: sqwrc_pins_model.sv */
// Purpose: Oscillator, supplies and manual clear switch beside sqwrc_top
// Assumes: Bench sets supply and switch levels
// Notes: Oscillator runs free; clear pin pulled up when released
`timescale 1ns/1ps
module sqwrc_pins_model #(
	parameter int OSC_HALF_NS = 15259
) (
	input wire logic vcc_on,
	input wire logic aux_on,
	input wire logic clr_on,
	output logic osc_32k_in,
	output logic vcc_above_trip,
	output logic aux_battery_in,
	output logic user_ram_clear_n
);
	logic osc_q = 1'b0;
	always #(OSC_HALF_NS) osc_q = ~osc_q;
	assign osc_32k_in = osc_q;
	assign vcc_above_trip = vcc_on;
	assign aux_battery_in = aux_on;
	assign user_ram_clear_n = ~clr_on;
endmodule // sqwrc_pins_model

/* File: sqwrc_tb.sv */
// Purpose: Self-checking bench for sqwrc_top
// Assumes: Fast oscillator, half period 210 ns, to keep runs short
// Notes: APB driver queues notes, monitor compares at pready
`timescale 1ns/1ps
module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] d;
	logic pready, pslverr, osc, vcc, aux, clr_n, sq, oe_n;
	logic vcc_on = 1'b1;
	logic aux_on = 1'b0;
	logic clr_on = 1'b0;
	logic [33:0] q[$];
	logic [33:0] e;
	int err_count = 0;
	int checks = 0;
	int seed = 5;
	time t0;
	always #20 pclk = ~pclk;
	sqwrc_top sqwrc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .osc_32k_in(osc), .vcc_above_trip(vcc), .aux_battery_in(aux),
		.user_ram_clear_n(clr_n), .square_wave_out(sq), .square_wave_oe_n(oe_n));
	sqwrc_pins_model #(.OSC_HALF_NS(210)) sqwrc_pins_model_i (.vcc_on(vcc_on),
		.aux_on(aux_on), .clr_on(clr_on), .osc_32k_in(osc), .vcc_above_trip(vcc),
		.aux_battery_in(aux), .user_ram_clear_n(clr_n));
	task complete_run;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		checks++;
		if (g !== x) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic er,
		input logic [31:0] x);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		q.push_back({~w, er, x});
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 9);
		if (n >= 9) begin
			err_count++;
			complete_run;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	always @(posedge pclk) begin
		if (pready === 1'b1) begin
			e = q.pop_front();
			chk({31'h0, pslverr}, {31'h0, e[32]});
			if (e[33])
				chk(prdata, e[31:0]);
		end
	end
	// Sampled at negedge so outputs have settled
	task tog;
		int n;
		logic l;
		n = 0;
		l = sq;
		while (sq === l) begin
			@(negedge pclk);
			n++;
			if (n > 3000) begin
				err_count++;
				complete_run;
			end
		end
	endtask
	// First two toggles after a rate change may come early, so skip both
	task half_chk(input int h);
		tog;
		tog;
		t0 = $time;
		tog;
		chk({31'h0, ($time - t0 > h - 100) && ($time - t0 < h + 100)}, 32'h1);
	endtask
	task steady;
		int c;
		logic l;
		c = 0;
		repeat (4) @(negedge pclk);
		l = sq;
		repeat (400) begin
			@(negedge pclk);
			c += (sq !== l);
		end
		chk(c, 0);
		chk({31'h0, l}, 32'h0);
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (10) @(posedge pclk);
		apb(0, sqwrc_pkg::OFF_EXT_CTRL, 0, 0, 32'h1);
		apb(0, sqwrc_pkg::OFF_CTRL_A, 0, 0, 32'h20);
		half_chk(210);
		apb(1, sqwrc_pkg::OFF_CTRL_A, 32'h23, 0, 0);
		half_chk(210);
		$display("test force done");
		apb(1, sqwrc_pkg::OFF_EXT_CTRL, 0, 0, 0);
		steady;
		chk({31'h0, oe_n}, 0);
		apb(1, sqwrc_pkg::OFF_CTRL_B, 32'h8, 0, 0);
		for (int c = 1; c < 10; c++) begin
			apb(1, sqwrc_pkg::OFF_CTRL_A, 32'h20 | c, 0, 0);
			half_chk(420 << (c < 3 ? c + 5 : c - 2));
		end
		// Divider control 11x holds the chain in reset, so the tap stays low
		apb(1, sqwrc_pkg::OFF_CTRL_A, 32'h63, 0, 0);
		steady;
		apb(1, sqwrc_pkg::OFF_CTRL_A, 32'h20, 0, 0);
		steady;
		$display("test rates done");
		for (int i = 0; i < 114; i += 113) begin
			d = $random(seed);
			apb(1, sqwrc_pkg::OFF_RAM_BASE + 12'(i * 4), d, 0, 0);
			apb(0, sqwrc_pkg::OFF_RAM_BASE + 12'(i * 4), 0, 0, d & 32'hFF);
		end
		apb(0, 12'h3C8, 0, 1, 0);
		$display("test ram done");
		aux_on <= 1'b1;
		apb(1, sqwrc_pkg::OFF_EXT_CTRL, 32'h3, 0, 0);
		vcc_on <= 1'b0;
		repeat (8) @(posedge pclk);
		half_chk(210);
		chk({31'h0, oe_n}, 0);
		apb(1, sqwrc_pkg::OFF_RAM_BASE, 0, 1, 0);
		apb(0, sqwrc_pkg::OFF_RAM_BASE, 0, 1, 0);
		aux_on <= 1'b0;
		repeat (8) @(posedge pclk);
		chk({31'h0, oe_n}, 1);
		clr_on <= 1'b1;
		repeat (130) @(posedge pclk);
		clr_on <= 1'b0;
		repeat (8) @(posedge pclk);
		vcc_on <= 1'b1;
		repeat (10) @(posedge pclk);
		apb(0, sqwrc_pkg::OFF_RAM_BASE, 0, 0, 32'hFF);
		apb(0, sqwrc_pkg::OFF_RAM_BASE + 12'h1C4, 0, 0, 32'hFF);
		apb(0, sqwrc_pkg::OFF_CTRL_B, 0, 0, 32'h8);
		apb(0, sqwrc_pkg::OFF_EXT_CTRL, 0, 0, 32'h3);
		apb(0, sqwrc_pkg::OFF_STATUS, 0, 0, 32'h9);
		$display("test power fail done");
		repeat (4) @(posedge pclk);
		complete_run;
	end
endmodule // tb
